// ---- design/rtt_pkg.sv ----
// package of register map, field layout and timing constants for the reload timer trio
package rtt_pkg;
   // ----------------------------------------
   // register byte offsets on the apb bus
   // ----------------------------------------
   localparam logic [7:0] OFF_MODE = 8'h00; // multi-mode timer mode register
   localparam logic [7:0] OFF_PRE_LATCH = 8'h04; // shared prescaler latch
   localparam logic [7:0] OFF_TX_LATCH = 8'h08; // multi-mode timer latch
   localparam logic [7:0] OFF_T1_LATCH = 8'h0c; // periodic timer 1 latch
   localparam logic [7:0] OFF_T2_LATCH = 8'h10; // periodic timer 2 latch
   localparam logic [7:0] OFF_TX_COUNT = 8'h14; // multi-mode counter, read only
   localparam logic [7:0] OFF_T1_COUNT = 8'h18; // periodic counter 1, read only
   localparam logic [7:0] OFF_T2_COUNT = 8'h1c; // periodic counter 2, read only
   localparam logic [7:0] OFF_IRQ_STAT = 8'h20; // sticky requests, write one to clear
   localparam logic [7:0] OFF_IRQ_MASK = 8'h24; // interrupt enables
   // ----------------------------------------
   // mode register fields
   // ----------------------------------------
   localparam int MODE_LO = 0; // operating mode, two bits
   localparam int MODE_W = 2;
   localparam int EDGE_BIT = 2; // active-edge select
   localparam int SRC_BIT = 3; // timer-mode source: 0 prescaler out, 1 clock/16
   localparam int STOP_BIT = 4; // count stop
   localparam int MODE_REG_W = 5;
   localparam logic [1:0] MODE_TIMER = 2'h0;
   localparam logic [1:0] MODE_PULSE = 2'h1;
   localparam logic [1:0] MODE_EVENT = 2'h2;
   localparam logic [1:0] MODE_WIDTH = 2'h3;
   // ----------------------------------------
   // interrupt bits
   // ----------------------------------------
   localparam int IRQ_TX = 0; // multi-mode timer underflow
   localparam int IRQ_T1 = 1; // periodic timer 1 underflow
   localparam int IRQ_T2 = 2; // periodic timer 2 underflow
   localparam int IRQ_PIN = 3; // active edge on timer pin
   localparam int IRQ_W = 4;
   // ----------------------------------------
   // widths, reset values, timing
   // ----------------------------------------
   localparam int CNT_W = 8;
   localparam logic [7:0] LATCH_RST = 8'hff;
   localparam int SYS_DIV = 16; // fixed divide of the system clock
   localparam logic [3:0] DIV_LAST = 4'(SYS_DIV - 1);
endpackage

// ---- design/rtt_top.sv ----
// reload timer trio: prescaler, two periodic timers and a multi-mode timer behind apb
// Notes on behaviour
// [RULE_01] each counter divides by latch plus one
// [RULE_02] count down, reload on underflow, continue
// [RULE_03] underflow sets that timer's request bit
// [RULE_04] prescaler on clock/16 feeds timers 1, 2
// [RULE_05] multi-mode timer has four operating modes
// [RULE_06] timer mode counts the selected source
// [RULE_07] pulse mode counts clock/16, toggles at zero
// [RULE_08] pulse output starts high if edge zero
// [RULE_09] software sets pin direction to output first
// [RULE_10] event mode counts chosen pin edges
// [RULE_11] width mode counts clock/16 during pin level
// [RULE_12] stop bit halts counting in every mode
// [RULE_13] active pin edge raises pin request
// [RULE_14] software masks before changing edge select
// [RULE_15] clearing stop resumes without reloading
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module rtt_top (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic timer_event_pin_in,
   output logic timer_event_pin_out,
   output logic timer_event_pin_oe_n,
   output logic irq
);
   // ----------------------------------------
   // registers and state
   // ----------------------------------------
   logic [4:0] mode_reg, mode_next; // mode, edge, source, stop
   logic [7:0] pre_latch_reg, pre_latch_next;
   logic [7:0] latch_reg [3];  // 0 multi-mode, 1 timer1, 2 timer2
   logic [7:0] latch_next [3];
   logic [7:0] cnt_reg [3]; // down counters
   logic [7:0] cnt_next [3];
   logic [7:0] pre_cnt_reg, pre_cnt_next; // prescaler counter
   logic [3:0] div_reg, div_next; // clock/16 divider
   logic [3:0] stat_reg, stat_next; // sticky requests
   logic [3:0] mask_reg, mask_next;
   logic [31:0] prdata_next;
   logic pready_next, pslverr_next, irq_next;
   logic pin_out_reg, pin_out_next; // pulse output level
   logic pin_s1_reg, pin_s2_reg, pin_s3_reg; // synchroniser and edge history
   logic div_tick; // one-cycle clock/16 enable
   logic pre_tick; // prescaler underflow pulse
   logic [2:0] tick; // count pulse per timer
   logic [2:0] uflow; // underflow per timer
   logic pin_rise, pin_fall, pin_edge;
   logic wr_en, rd_en;
   logic [1:0] mode;
   logic edge_sel;

   // decode one register offset against the current address
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      return a == off;
   endfunction

   assign wr_en = psel && penable && pwrite && !pready;
   assign rd_en = psel && penable && !pwrite && !pready;
   assign mode = mode_reg[rtt_pkg::MODE_LO +: rtt_pkg::MODE_W];
   assign edge_sel = mode_reg[rtt_pkg::EDGE_BIT];

   // ----------------------------------------
   // pin synchroniser, stage one read only by stage two
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         pin_s1_reg <= 1'b0;
         pin_s2_reg <= 1'b0;
         pin_s3_reg <= 1'b0;
      end else begin
         pin_s1_reg <= timer_event_pin_in;
         pin_s2_reg <= pin_s1_reg;
         pin_s3_reg <= pin_s2_reg;
      end
   end
   assign pin_rise = pin_s2_reg && !pin_s3_reg;
   assign pin_fall = !pin_s2_reg && pin_s3_reg;
   assign pin_edge = edge_sel ? pin_fall : pin_rise; // RULE_13

   // ----------------------------------------
   // count pulses for prescaler and timers
   // ----------------------------------------
   always_comb begin
      div_tick = (div_reg == rtt_pkg::DIV_LAST); // RULE_04
      pre_tick = div_tick && (pre_cnt_reg == 8'h00); // RULE_01
      tick[1] = pre_tick; // RULE_04
      tick[2] = pre_tick;
      // multi-mode timer source chosen by mode
      case (mode) // RULE_05
         rtt_pkg::MODE_TIMER: tick[0] = mode_reg[rtt_pkg::SRC_BIT] ? div_tick : pre_tick; // RULE_06
         rtt_pkg::MODE_PULSE: tick[0] = div_tick; // RULE_07
         rtt_pkg::MODE_EVENT: tick[0] = pin_edge; // RULE_10
         rtt_pkg::MODE_WIDTH: tick[0] = div_tick && (pin_s2_reg != edge_sel); // RULE_11
         default: tick[0] = 1'b0;
      endcase
      if (mode_reg[rtt_pkg::STOP_BIT]) begin
         tick[0] = 1'b0; // RULE_12
      end
   end

   // ----------------------------------------
   // counters: next values
   // ----------------------------------------
   always_comb begin
      div_next = div_reg + 4'h1;
      pre_cnt_next = pre_cnt_reg;
      if (div_tick) begin
         pre_cnt_next = (pre_cnt_reg == 8'h00) ? pre_latch_reg : pre_cnt_reg - 8'h01; // RULE_01
      end
   end

   // one reloading down counter per timer
   generate
      for (genvar i = 0; i < 3; i++) begin : g_tmr
         assign uflow[i] = tick[i] && (cnt_reg[i] == 8'h00); // RULE_02
         always_comb begin
            cnt_next[i] = cnt_reg[i]; // held while stopped, RULE_15
            if (tick[i]) begin
               cnt_next[i] = uflow[i] ? latch_reg[i] : cnt_reg[i] - 8'h01; // RULE_02
            end
         end
         always_ff @(posedge clk) begin
            if (rst) begin
               cnt_reg[i] <= rtt_pkg::LATCH_RST;
               latch_reg[i] <= rtt_pkg::LATCH_RST;
            end else begin
               cnt_reg[i] <= cnt_next[i];
               latch_reg[i] <= latch_next[i];
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // register writes, status and pulse output
   // ----------------------------------------
   always_comb begin
      mode_next = mode_reg;
      pre_latch_next = pre_latch_reg;
      latch_next = latch_reg;
      mask_next = mask_reg;
      pin_out_next = pin_out_reg;
      stat_next = stat_reg;
      if (wr_en) begin
         if (hit(paddr, rtt_pkg::OFF_MODE)) begin
            mode_next = pwdata[rtt_pkg::MODE_REG_W-1:0];
         end
         if (hit(paddr, rtt_pkg::OFF_PRE_LATCH)) begin
            pre_latch_next = pwdata[7:0];
         end
         if (hit(paddr, rtt_pkg::OFF_TX_LATCH)) begin
            latch_next[0] = pwdata[7:0];
         end
         if (hit(paddr, rtt_pkg::OFF_T1_LATCH)) begin
            latch_next[1] = pwdata[7:0];
         end
         if (hit(paddr, rtt_pkg::OFF_T2_LATCH)) begin
            latch_next[2] = pwdata[7:0];
         end
         if (hit(paddr, rtt_pkg::OFF_IRQ_MASK)) begin
            mask_next = pwdata[3:0];
         end
         if (hit(paddr, rtt_pkg::OFF_IRQ_STAT)) begin
            stat_next = stat_reg & ~pwdata[3:0]; // write one clears
         end
      end
      // events set after the clear so a same-cycle set wins
      stat_next[rtt_pkg::IRQ_TX] = stat_next[rtt_pkg::IRQ_TX] | uflow[0]; // RULE_03
      stat_next[rtt_pkg::IRQ_T1] = stat_next[rtt_pkg::IRQ_T1] | uflow[1]; // RULE_03
      stat_next[rtt_pkg::IRQ_T2] = stat_next[rtt_pkg::IRQ_T2] | uflow[2]; // RULE_03
      stat_next[rtt_pkg::IRQ_PIN] = stat_next[rtt_pkg::IRQ_PIN] | pin_edge; // RULE_13
      // pulse output: preset level on mode write, toggle when count reaches zero
      if (mode != rtt_pkg::MODE_PULSE || (wr_en && hit(paddr, rtt_pkg::OFF_MODE))) begin
         pin_out_next = !mode_next[rtt_pkg::EDGE_BIT]; // RULE_08
      end else if (tick[0] && cnt_next[0] == 8'h00) begin
         pin_out_next = !pin_out_reg; // RULE_07
      end
      irq_next = |(stat_next & mask_next);
   end

   // ----------------------------------------
   // apb read path and ready
   // ----------------------------------------
   always_comb begin
      prdata_next = 32'h0000_0000;
      pslverr_next = 1'b0;
      pready_next = psel && penable && !pready;
      if (rd_en || wr_en) begin
         case (paddr)
            rtt_pkg::OFF_MODE: prdata_next = {27'h0, mode_reg};
            rtt_pkg::OFF_PRE_LATCH: prdata_next = {24'h0, pre_latch_reg};
            rtt_pkg::OFF_TX_LATCH: prdata_next = {24'h0, latch_reg[0]};
            rtt_pkg::OFF_T1_LATCH: prdata_next = {24'h0, latch_reg[1]};
            rtt_pkg::OFF_T2_LATCH: prdata_next = {24'h0, latch_reg[2]};
            rtt_pkg::OFF_TX_COUNT: prdata_next = {24'h0, cnt_reg[0]};
            rtt_pkg::OFF_T1_COUNT: prdata_next = {24'h0, cnt_reg[1]};
            rtt_pkg::OFF_T2_COUNT: prdata_next = {24'h0, cnt_reg[2]};
            rtt_pkg::OFF_IRQ_STAT: prdata_next = {28'h0, stat_reg};
            rtt_pkg::OFF_IRQ_MASK: prdata_next = {28'h0, mask_reg};
            default: pslverr_next = 1'b1; // unmapped address
         endcase
         if (!rd_en) begin
            prdata_next = 32'h0000_0000;
         end
      end
   end

   // ----------------------------------------
   // state registers
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         mode_reg <= 5'h00;
         pre_latch_reg <= rtt_pkg::LATCH_RST;
         pre_cnt_reg <= rtt_pkg::LATCH_RST;
         div_reg <= 4'h0;
         stat_reg <= 4'h0;
         mask_reg <= 4'h0;
         pin_out_reg <= 1'b1;
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         irq <= 1'b0;
         timer_event_pin_out <= 1'b1;
         timer_event_pin_oe_n <= 1'b1;
      end else begin
         mode_reg <= mode_next;
         pre_latch_reg <= pre_latch_next;
         pre_cnt_reg <= pre_cnt_next;
         div_reg <= div_next;
         stat_reg <= stat_next;
         mask_reg <= mask_next;
         pin_out_reg <= pin_out_next;
         prdata <= prdata_next;
         pready <= pready_next;
         pslverr <= pslverr_next;
         irq <= irq_next;
         timer_event_pin_out <= pin_out_next;
         timer_event_pin_oe_n <= mode_next[rtt_pkg::MODE_LO +: rtt_pkg::MODE_W]
            != rtt_pkg::MODE_PULSE; // pin driven only in pulse mode, RULE_09
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   sequence s_t1_zero_tick;
      tick[1] && cnt_reg[1] == 8'h00;
   endsequence
   chk_t1_reload: assert property (@(posedge clk) disable iff (rst) // RULE_02
      s_t1_zero_tick |=> cnt_reg[1] == $past(latch_reg[1]))
      else $error("timer 1 did not reload on underflow");
   chk_tx_decrement: assert property (@(posedge clk) disable iff (rst) // RULE_01
      tick[0] && cnt_reg[0] != 8'h00 |=> cnt_reg[0] == $past(cnt_reg[0]) - 8'h01)
      else $error("multi-mode timer did not count down");
   chk_uflow_sets_req: assert property (@(posedge clk) disable iff (rst) // RULE_03
      uflow[1] |=> stat_reg[rtt_pkg::IRQ_T1])
      else $error("underflow did not set request");
   chk_div_period: assert property (@(posedge clk) disable iff (rst) // RULE_04
      div_tick |=> !div_tick [*8] ##8 div_tick)
      else $error("clock divide is not sixteen");
   chk_stop_holds: assert property (@(posedge clk) disable iff (rst) // RULE_12
      mode_reg[rtt_pkg::STOP_BIT] && $stable(mode_reg) |=> $stable(cnt_reg[0]))
      else $error("stopped timer still counted");
   chk_event_edge: assert property (@(posedge clk) disable iff (rst) // RULE_10
      mode == rtt_pkg::MODE_EVENT && !mode_reg[rtt_pkg::STOP_BIT]
      && $rose(pin_s2_reg) && !edge_sel |-> tick[0])
      else $error("rising edge not counted");
   chk_width_gate: assert property (@(posedge clk) disable iff (rst) // RULE_11
      mode == rtt_pkg::MODE_WIDTH && pin_s2_reg == edge_sel |-> !tick[0])
      else $error("width mode counted at wrong level");
   chk_pulse_toggle: assert property (@(posedge clk) disable iff (rst) // RULE_07
      mode == rtt_pkg::MODE_PULSE && $stable(mode_reg) && !$stable(pin_out_reg)
      |-> cnt_reg[0] == 8'h00)
      else $error("pulse output toggled away from zero");
   chk_pin_req: assert property (@(posedge clk) disable iff (rst) // RULE_13
      pin_edge |=> stat_reg[rtt_pkg::IRQ_PIN])
      else $error("pin edge did not set request");
   // prescaler reloads its latch after reaching zero
   chk_pre_reload: assert property (@(posedge clk) disable iff (rst) // RULE_01
      div_tick && pre_cnt_reg == 8'h00 |=> pre_cnt_reg == $past(pre_latch_reg))
      else $error("prescaler did not reload on underflow");
   // any mode write in pulse mode presets the output level from edge select
   chk_pulse_preset: assert property (@(posedge clk) disable iff (rst) // RULE_08
      mode == rtt_pkg::MODE_PULSE && $changed(mode_reg) |-> pin_out_reg == !edge_sel)
      else $error("pulse output start level wrong");
   // releasing stop keeps the held count, no reload
   chk_resume_hold: assert property (@(posedge clk) disable iff (rst) // RULE_15
      $fell(mode_reg[rtt_pkg::STOP_BIT]) |-> cnt_reg[0] == $past(cnt_reg[0]))
      else $error("count changed when stop was released");
   // interrupt output follows the unmasked sticky requests
   chk_irq_level: assert property (@(posedge clk) disable iff (rst) // RULE_03
      irq == (|(stat_reg & mask_reg)))
      else $error("interrupt level does not match requests");
endmodule

// ---- tb/rtt_pin_model.sv ----
// partner model: external pulse source on the timer pin, a plain load while the block drives
`timescale 1ns/1ps
module rtt_pin_model (
   input wire logic clk,
   input wire logic pin_out,
   input wire logic oe_n,
   output logic pin_in
);
   // ----------------------------------------
   // pin source and wire level
   // ----------------------------------------
   logic src_level = 1'b0; // level the external source drives
   // the source steps back while the block drives the pin
   assign pin_in = oe_n ? src_level : pin_out;
   // drive one level for a number of cycles, changed just after an edge
   task automatic set_level(input logic lvl, input int hold);
      @(posedge clk);
      src_level <= lvl;
      repeat (hold - 1) @(posedge clk);
   endtask
   // pulses of four cycles at each level, first level given
   task automatic pulses(input int n, input logic first);
      for (int i = 0; i < n; i++) begin
         set_level(first, 4);
         set_level(!first, 4);
      end
   endtask
endmodule

// ---- tb/tb.sv ----
// self-checking bench for the reload timer trio
`timescale 1ns/1ps
module tb;
   logic clk, rst, psel, penable, pwrite, pready, pslverr, err;
   logic pin_in, pin_out, oe_n, irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q, v;
   int failures = 0;
   int samples_checked = 0;
   int cyc = 0;
   int t0;
   logic [7:0] ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h20, 8'h24, 8'h28};
   logic [31:0] rv [8] = '{32'h0, 32'hff, 32'hff, 32'hff, 32'hff, 32'h0, 32'h0, 32'h0};
   rtt_top rtt_top_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .timer_event_pin_in(pin_in), .timer_event_pin_out(pin_out),
      .timer_event_pin_oe_n(oe_n), .irq(irq));
   rtt_pin_model rtt_pin_model_i (.clk(clk), .pin_out(pin_out), .oe_n(oe_n), .pin_in(pin_in));
   // ----------------------------------------
   // clock, watchdog and shared tasks
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // cycle count; a hang ends the run as a mismatch
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         failures++;
         results();
      end
   end
   task automatic results();
      $display("checked %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %s expected %0h seen %0h", n, e, g);
      end
   endtask
   task automatic chk_rng(input string n, input int lo, input int hi, input logic [31:0] g);
      samples_checked++;
      if ((g >= lo && g <= hi) !== 1'b1) begin
         failures++;
         $display("MISMATCH %s expected %0d to %0d seen %0h", n, lo, hi, g);
      end
   endtask
   // one apb transfer: setup, access held until pready, one idle edge after
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
      chk("apb wait bound", 0, 32'(n == 20));
   endtask
   // bounded wait for irq (p=0) or pin output (p=1) to reach a level
   task automatic wait_lvl(input logic p, input logic l);
      int n;
      n = 0;
      while ((p ? pin_out : irq) !== l && n < 30000) begin
         @(posedge clk);
         n++;
      end
      chk("level wait bound", 0, 32'(n == 30000));
   endtask
   // cycles between two underflow requests of one source
   task automatic irq_per(input int b, input int e);
      apb(1'b1, 8'h24, 32'h1 << b);
      apb(1'b1, 8'h20, 32'hf);
      wait_lvl(1'b0, 1'b1);
      t0 = cyc;
      apb(1'b1, 8'h20, 32'h1 << b);
      wait_lvl(1'b0, 1'b0);
      wait_lvl(1'b0, 1'b1);
      chk("irq period", e, cyc - t0);
   endtask
   // mode word, timer source always clock/16
   function automatic logic [31:0] mv(input logic [1:0] m, input logic e, input logic s);
      return 32'(m) | (32'(e) << rtt_pkg::EDGE_BIT) | (32'(s) << rtt_pkg::STOP_BIT)
         | (32'h1 << rtt_pkg::SRC_BIT);
   endfunction
   // ----------------------------------------
   // test sequence
   // ----------------------------------------
   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      // reset values, then an unmapped place that must be refused
      for (int i = 0; i < 8; i++) begin
         apb(1'b0, ra[i], 32'h0);
         chk("reset read", rv[i], q);
         chk("slave error", 32'(i == 7), 32'(err));
      end
      chk("pin released", 1, 32'(oe_n));
      $display("test reset done");
      // latches: prescaler 1, timer 1 2, timer 2 0, multi-mode 3
      apb(1'b1, 8'h04, 32'h1);
      apb(1'b1, 8'h0c, 32'h2);
      apb(1'b1, 8'h10, 32'h0);
      apb(1'b1, 8'h08, 32'h3);
      apb(1'b1, 8'h00, mv(rtt_pkg::MODE_TIMER, 1'b0, 1'b0));
      irq_per(rtt_pkg::IRQ_TX, 64);
      irq_per(rtt_pkg::IRQ_T1, 96);
      irq_per(rtt_pkg::IRQ_T2, 32);
      // timer mode on the prescaler output: 2 x 16 x 4 cycles
      apb(1'b1, 8'h00, 32'(rtt_pkg::MODE_TIMER));
      irq_per(rtt_pkg::IRQ_TX, 128);
      $display("test periods done");
      // pulse output: start level per edge select, toggle every latch+1 ticks
      for (int e = 0; e < 2; e++) begin
         apb(1'b1, 8'h00, mv(rtt_pkg::MODE_PULSE, e[0], 1'b1));
         chk("pulse start level", 32'(!e[0]), 32'(pin_out));
         chk("pin driven", 0, 32'(oe_n));
         apb(1'b1, 8'h00, mv(rtt_pkg::MODE_PULSE, e[0], 1'b0));
         v = 32'(pin_out);
         wait_lvl(1'b1, !v[0]);
         t0 = cyc;
         wait_lvl(1'b1, v[0]);
         chk("toggle gap", 64, cyc - t0);
      end
      $display("test pulse done");
      // large latch, then stop and resume without reload
      apb(1'b1, 8'h00, mv(rtt_pkg::MODE_TIMER, 1'b0, 1'b0));
      apb(1'b1, 8'h08, 32'h80);
      irq_per(rtt_pkg::IRQ_TX, 2064);
      apb(1'b1, 8'h00, mv(rtt_pkg::MODE_TIMER, 1'b0, 1'b1));
      apb(1'b0, 8'h14, 32'h0);
      v = q;
      repeat (100) @(posedge clk);
      apb(1'b0, 8'h14, 32'h0);
      chk("held count", v, q);
      apb(1'b1, 8'h00, mv(rtt_pkg::MODE_TIMER, 1'b0, 1'b0));
      repeat (40) @(posedge clk);
      apb(1'b0, 8'h14, 32'h0);
      chk_rng("resumed count", 2, 3, v - q);
      $display("test stop done");
      // event counting and pulse width per edge select
      for (int e = 0; e < 2; e++) begin
         apb(1'b1, 8'h08, 32'hff);
         rtt_pin_model_i.set_level(e[0], 10);
         apb(1'b1, 8'h24, 32'h0);
         apb(1'b1, 8'h00, mv(rtt_pkg::MODE_EVENT, e[0], 1'b0));
         apb(1'b1, 8'h20, 32'hf);
         apb(1'b0, 8'h14, 32'h0);
         v = q;
         rtt_pin_model_i.pulses(5, !e[0]);
         repeat (10) @(posedge clk);
         apb(1'b0, 8'h14, 32'h0);
         chk("event count", 5, 8'(v - q));
         apb(1'b0, 8'h20, 32'h0);
         chk("pin request", 1, 32'(q[rtt_pkg::IRQ_PIN]));
         apb(1'b1, 8'h00, mv(rtt_pkg::MODE_WIDTH, e[0], 1'b0));
         apb(1'b0, 8'h14, 32'h0);
         v = q;
         repeat (100) @(posedge clk);
         apb(1'b0, 8'h14, 32'h0);
         chk("idle level count", v, q);
         rtt_pin_model_i.set_level(!e[0], 160);
         rtt_pin_model_i.set_level(e[0], 10);
         apb(1'b0, 8'h14, 32'h0);
         chk_rng("width count", 9, 11, 8'(v - q));
      end
      $display("test event and width done");
      results();
   end
endmodule
